//--- load_adaptive_current_regs.svh
// constants for the load-adaptive current regulator and its serial configuration port
// assumes core_clk at 40 MHz and a serial clock well below half of it

`ifndef LOAD_ADAPTIVE_CURRENT_REGS_SVH
`define LOAD_ADAPTIVE_CURRENT_REGS_SVH

`define CMD_BITS 20
`define SCALE_BITS 5
`define SCALE_DIV_SHIFT 5
`define THR_SHIFT 5
`define MEAS_BITS 10
`define FILTER_SAMPLES 4
`define FILTER_SHIFT 2
`define DN_COUNT_CODE0 6'h20
`define DN_COUNT_CODE1 6'h08
`define DN_COUNT_CODE2 6'h02
`define DN_COUNT_CODE3 6'h01
`define SCALE_RESET 5'h1F

`endif

//--- load_adaptive_current_pkg.sv
// types shared by the regulator top and its serial configuration port
// assumes the constants header is compiled alongside
package load_adaptive_current_pkg;

  // user settings of the regulator, held outside this block
  typedef struct packed {
    logic [4:0] current_scale;
    logic [1:0] current_step_up;
    logic [1:0] current_step_down_count;
    logic min_current_quarter_sel;
    logic load_filter_en;
    logic [3:0] lower_load_threshold;
    logic [3:0] upper_load_hysteresis;
  } regulator_cfg_t;

  // one command word received on chip select rise
  typedef struct packed {
    logic [19:0] word;
    logic valid;
  } serial_cmd_t;

  typedef enum logic [0:0] {
    PORT_IDLE = 1'b0,
    PORT_ACTIVE = 1'b1
  } port_state_t;

endpackage

//--- serial_cfg_port.sv
// four-wire serial configuration port, mode 3, sampled by core_clk
// assumes sck, sdi, csn are asynchronous pins and sck runs below core_clk/2
`timescale 1ns/1ps
`include "load_adaptive_current_regs.svh"
module serial_cfg_port
  import load_adaptive_current_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sdi,
  input wire logic csn,
  input wire logic [`CMD_BITS-1:0] resp_word,
  output logic sdo,
  output serial_cmd_t cmd
);

  logic [2:0] sck_s_r, sdi_s_r, csn_s_r;
  logic [2:0] sck_s_nxt, sdi_s_nxt, csn_s_nxt;
  logic [`CMD_BITS-1:0] shift_r, shift_nxt;
  logic sdo_r, sdo_nxt;
  serial_cmd_t cmd_r, cmd_nxt;
  port_state_t state_r, state_nxt;
  logic sck_rise, sck_fall, csn_fall, csn_rise;
  logic sdo_may_move;

  // two stages of synchroniser, the third stage is only for edge finding
  always_comb begin
    sck_s_nxt = {sck_s_r[1:0], sck};
    sdi_s_nxt = {sdi_s_r[1:0], sdi};
    csn_s_nxt = {csn_s_r[1:0], csn};
  end

  assign sck_rise = sck_s_r[1] & ~sck_s_r[2];
  assign sck_fall = ~sck_s_r[1] & sck_s_r[2];
  assign csn_fall = ~csn_s_r[1] & csn_s_r[2];
  assign csn_rise = csn_s_r[1] & ~csn_s_r[2];
  // the only two events that may load a new bit onto data out
  assign sdo_may_move = sck_fall | csn_fall;

  // shift engine; the response is loaded at select fall so its msb leads
  always_comb begin
    shift_nxt = shift_r;
    sdo_nxt = sdo_r;
    state_nxt = state_r;
    cmd_nxt = '{word: cmd_r.word, valid: 1'b0};
    unique case (state_r)
      PORT_IDLE: begin
        if (csn_fall) begin
          state_nxt = PORT_ACTIVE;
          shift_nxt = resp_word;
          sdo_nxt = resp_word[`CMD_BITS-1];
        end
      end
      PORT_ACTIVE: begin
        if (csn_rise) begin
          state_nxt = PORT_IDLE;
          cmd_nxt = '{word: shift_r, valid: 1'b1};
        end else if (sck_rise) begin
          shift_nxt = {shift_r[`CMD_BITS-2:0], sdi_s_r[1]};
        end else if (sck_fall) begin
          sdo_nxt = shift_r[`CMD_BITS-1];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sck_s_r <= 3'h7;
      sdi_s_r <= 3'h0;
      csn_s_r <= 3'h7;
      shift_r <= 20'h00000;
      sdo_r <= 1'b0;
      cmd_r <= '0;
      state_r <= PORT_IDLE;
    end else begin
      sck_s_r <= sck_s_nxt;
      sdi_s_r <= sdi_s_nxt;
      csn_s_r <= csn_s_nxt;
      shift_r <= shift_nxt;
      sdo_r <= sdo_nxt;
      cmd_r <= cmd_nxt;
      state_r <= state_nxt;
    end
  end

  assign sdo = sdo_r;
  assign cmd = cmd_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence sel_rise_active_s;
    csn_rise && state_r == PORT_ACTIVE;
  endsequence

  cmd_on_rise_a: assert property (sel_rise_active_s |=> cmd.valid && cmd.word == $past(shift_r))
    else $error("command not latched on select rise");
  cmd_pulse_a: assert property (cmd.valid |=> !cmd.valid)
    else $error("command strobe longer than one cycle");
  sdo_timing_a: assert property ($changed(sdo) |-> $past(sdo_may_move))
    else $error("data out changed outside a falling edge");
  shift_in_a: assert property (state_r == PORT_ACTIVE && !csn_rise && sck_rise
    |=> shift_r[0] == $past(sdi_s_r[1]) && shift_r[19:1] == $past(shift_r[18:0]))
    else $error("shift register did not take data in");
  idle_quiet_a: assert property (state_r == PORT_IDLE && !csn_fall |=> $stable(shift_r))
    else $error("shift register moved while deselected");

endmodule // serial_cfg_port

//--- load_adaptive_current_spi_cfg.sv
// load-adaptive coil current regulator with its serial configuration port
// assumes load measurements and coil values come from logic on core_clk,
// one measurement strobe per motor full step
`timescale 1ns/1ps
`include "load_adaptive_current_regs.svh"
module load_adaptive_current_spi_cfg
  import load_adaptive_current_pkg::*;
#(
  parameter int COIL_W = 9,
  parameter int STATUS_W = 15
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sdi,
  input wire logic csn,
  output logic sdo,
  input wire regulator_cfg_t cfg,
  input wire logic [`MEAS_BITS-1:0] load_measurement,
  input wire logic load_measurement_valid,
  input wire logic [COIL_W-1:0] coil_a_in,
  input wire logic [COIL_W-1:0] coil_b_in,
  output logic [COIL_W-1:0] coil_a_out,
  output logic [COIL_W-1:0] coil_b_out,
  input wire logic [STATUS_W-1:0] status_bits,
  output logic [`SCALE_BITS-1:0] actual_current_scale,
  output serial_cmd_t cmd
);

  // ---- measurement filter
  logic [1:0] filt_cnt_r, filt_cnt_nxt;
  logic [`MEAS_BITS+1:0] filt_acc_r, filt_acc_nxt;
  logic [`MEAS_BITS-1:0] meas_r, meas_nxt;
  logic meas_valid_r, meas_valid_nxt;
  logic [`MEAS_BITS+1:0] filt_sum;

  assign filt_sum = filt_acc_r + {2'h0, load_measurement};

  // with the filter on only every fourth strobe reaches the regulator,
  // so the regulator slows down by the same factor
  always_comb begin
    filt_cnt_nxt = filt_cnt_r;
    filt_acc_nxt = filt_acc_r;
    meas_nxt = meas_r;
    meas_valid_nxt = 1'b0;
    if (load_measurement_valid) begin
      if (!cfg.load_filter_en) begin
        meas_nxt = load_measurement;
        meas_valid_nxt = 1'b1;
        filt_cnt_nxt = 2'h0;
        filt_acc_nxt = '0;
      end else if (filt_cnt_r == 2'(`FILTER_SAMPLES - 1)) begin
        meas_nxt = filt_sum[`MEAS_BITS+1:`FILTER_SHIFT];
        meas_valid_nxt = 1'b1;
        filt_cnt_nxt = 2'h0;
        filt_acc_nxt = '0;
      end else begin
        filt_cnt_nxt = filt_cnt_r + 2'h1;
        filt_acc_nxt = filt_sum;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      filt_cnt_r <= 2'h0;
      filt_acc_r <= '0;
      meas_r <= '0;
      meas_valid_r <= 1'b0;
    end else begin
      filt_cnt_r <= filt_cnt_nxt;
      filt_acc_r <= filt_acc_nxt;
      meas_r <= meas_nxt;
      meas_valid_r <= meas_valid_nxt;
    end
  end

  // ---- thresholds and limits
  logic [`MEAS_BITS-1:0] lower_thr, upper_thr;
  logic [4:0] thr_sum;
  logic [`SCALE_BITS-1:0] scale_floor;
  logic [5:0] step_inc;
  logic [5:0] dn_target;

  assign thr_sum = {1'b0, cfg.lower_load_threshold} + {1'b0, cfg.upper_load_hysteresis} + 5'h01;
  assign lower_thr = {1'b0, cfg.lower_load_threshold, 5'h00};
  assign upper_thr = {thr_sum, 5'h00};
  // floor is a plain shift of the user scale code, so a scale of 0 floors at 0
  assign scale_floor = cfg.min_current_quarter_sel ? (cfg.current_scale >> 2)
                                                   : (cfg.current_scale >> 1);
  // step widths are powers of two, so a shift replaces a lookup table
  assign step_inc = 6'h01 << cfg.current_step_up;

  always_comb begin
    unique case (cfg.current_step_down_count)
      2'h0: dn_target = `DN_COUNT_CODE0;
      2'h1: dn_target = `DN_COUNT_CODE1;
      2'h2: dn_target = `DN_COUNT_CODE2;
      2'h3: dn_target = `DN_COUNT_CODE3;
    endcase
  end

  // ---- regulator
  logic [`SCALE_BITS-1:0] scale_r, scale_nxt;
  logic [5:0] dn_cnt_r, dn_cnt_nxt;
  logic [5:0] scale_work;

  // the clamp runs every cycle, not only on a measurement, so a rewrite of
  // the user scale or the floor bit takes effect one cycle later, without waiting for a measurement
  always_comb begin
    scale_work = {1'b0, scale_r};
    dn_cnt_nxt = dn_cnt_r;
    if (meas_valid_r) begin
      if (meas_r < lower_thr) begin
        scale_work = {1'b0, scale_r} + step_inc;
        dn_cnt_nxt = 6'h00;
      end else if (meas_r >= upper_thr) begin
        if (dn_cnt_r + 6'h01 >= dn_target) begin
          dn_cnt_nxt = 6'h00;
          if (scale_r != 5'h00) begin
            scale_work = {1'b0, scale_r} - 6'h01;
          end
        end else begin
          dn_cnt_nxt = dn_cnt_r + 6'h01;
        end
      end
    end
    if (scale_work > {1'b0, cfg.current_scale}) begin
      scale_nxt = cfg.current_scale;
    end else if (scale_work < {1'b0, scale_floor}) begin
      scale_nxt = scale_floor;
    end else begin
      scale_nxt = scale_work[`SCALE_BITS-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scale_r <= `SCALE_RESET;
      dn_cnt_r <= 6'h00;
    end else begin
      scale_r <= scale_nxt;
      dn_cnt_r <= dn_cnt_nxt;
    end
  end

  assign actual_current_scale = scale_r;

  // ---- coil scaling by (scale+1)/32
  logic [5:0] scale_mult;
  logic [COIL_W+5:0] prod_a, prod_b;
  logic [COIL_W-1:0] coil_a_r, coil_a_nxt, coil_b_r, coil_b_nxt;

  assign scale_mult = {1'b0, scale_r} + 6'h01;

  // truncation instead of rounding keeps 32/32 an exact pass-through
  always_comb begin
    prod_a = {6'h00, coil_a_in} * {{COIL_W{1'b0}}, scale_mult};
    prod_b = {6'h00, coil_b_in} * {{COIL_W{1'b0}}, scale_mult};
    coil_a_nxt = prod_a[COIL_W+`SCALE_DIV_SHIFT-1:`SCALE_DIV_SHIFT];
    coil_b_nxt = prod_b[COIL_W+`SCALE_DIV_SHIFT-1:`SCALE_DIV_SHIFT];
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      coil_a_r <= '0;
      coil_b_r <= '0;
    end else begin
      coil_a_r <= coil_a_nxt;
      coil_b_r <= coil_b_nxt;
    end
  end

  assign coil_a_out = coil_a_r;
  assign coil_b_out = coil_b_r;

  // ---- serial port; status word carries the actual scale in its low bits
  logic [`CMD_BITS-1:0] resp_word;

  assign resp_word = {status_bits, scale_r};

  serial_cfg_port port_u (
    .core_clk (core_clk),
    .resetn (resetn),
    .sck (sck),
    .sdi (sdi),
    .csn (csn),
    .resp_word (resp_word),
    .sdo (sdo),
    .cmd (cmd)
  );

  // ---- checks
  // a rewrite of the user scale or the floor bit is clamped one cycle later,
  // so the range checks only look at cycles whose settings equal those of the
  // cycle before; otherwise a legal rewrite would trip them
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic cfg_steady;
  logic high_meas;
  logic mid_meas;
  logic cfg_seen_r, cfg_seen_nxt;
  regulator_cfg_t cfg_prev_r, cfg_prev_nxt;

  // settings one cycle back; the seen flag keeps the first cycle after
  // reset from counting as steady, whatever the settings are
  always_comb begin
    cfg_prev_nxt = cfg;
    cfg_seen_nxt = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg_prev_r <= '0;
      cfg_seen_r <= 1'b0;
    end else begin
      cfg_prev_r <= cfg_prev_nxt;
      cfg_seen_r <= cfg_seen_nxt;
    end
  end

  assign cfg_steady = cfg_seen_r && (cfg == cfg_prev_r);
  // plain flags for the high and mid measurement classes, so that they can be looked back at
  assign high_meas = meas_valid_r && meas_r >= upper_thr;
  assign mid_meas = meas_valid_r && meas_r >= lower_thr && meas_r < upper_thr;

  sequence low_meas_s;
    meas_valid_r && meas_r < lower_thr && cfg_steady;
  endsequence

  sequence high_meas_s;
    meas_valid_r && meas_r >= upper_thr;
  endsequence

  sequence mid_meas_s;
    mid_meas && cfg_steady;
  endsequence

  sequence settings_rewrite_s;
    !cfg_steady;
  endsequence

  sequence dn_due_s;
    high_meas_s ##0 (dn_cnt_r + 6'h01 >= dn_target) ##0 cfg_steady;
  endsequence

  scale_ceiling_a: assert property (cfg_steady |-> scale_r <= cfg.current_scale)
    else $error("scale above user current scale");
  scale_floor_a: assert property (cfg_steady |-> scale_r >= scale_floor)
    else $error("scale below selected floor");
  step_up_a: assert property (low_meas_s ##0 (scale_r + step_inc <= cfg.current_scale)
    |=> scale_r == $past(scale_r) + $past(step_inc[4:0]))
    else $error("scale did not rise by the step width");
  step_down_a: assert property (cfg_steady && $past(cfg_steady) && scale_r < $past(scale_r)
    |-> $past(high_meas) && $past(dn_cnt_r) + 6'h01 >= $past(dn_target))
    else $error("scale dropped without enough high measurements");
  dn_count_a: assert property (high_meas_s ##0 (dn_cnt_r + 6'h01 < dn_target) ##0 cfg_steady
    |=> scale_r == $past(scale_r))
    else $error("scale dropped early");
  filter_rate_a: assert property (cfg.load_filter_en && filt_cnt_r != 2'h3 |=> !meas_valid_r)
    else $error("filtered measurement too often");
  filter_avg_a: assert property (cfg.load_filter_en && load_measurement_valid && filt_cnt_r == 2'h3
    |=> meas_valid_r && meas_r == $past(filt_sum[11:2]))
    else $error("filtered value is not the average of four");
  raw_pass_a: assert property (!cfg.load_filter_en && load_measurement_valid
    |=> meas_valid_r && meas_r == $past(load_measurement))
    else $error("unfiltered measurement lost");
  coil_scale_a: assert property (1'b1 |=> coil_a_out == COIL_W'((32'($past(coil_a_in))
    * (32'($past(scale_r)) + 32'd1)) >> 5))
    else $error("coil current not scaled by the actual scale");
  coil_b_scale_a: assert property (1'b1 |=> coil_b_out == COIL_W'((32'($past(coil_b_in))
    * (32'($past(scale_r)) + 32'd1)) >> 5))
    else $error("second coil current not scaled by the actual scale");
  ceiling_clamp_a: assert property (low_meas_s ##0 ({1'b0, scale_r} + step_inc > {1'b0,
    cfg.current_scale}) |=> scale_r == $past(cfg.current_scale))
    else $error("raised scale not held at the user current scale");
  dn_step_a: assert property (dn_due_s ##0 (scale_r > scale_floor)
    |=> scale_r == $past(scale_r) - 5'h01)
    else $error("scale did not drop by one when the count was reached");
  low_clear_a: assert property (low_meas_s |=> dn_cnt_r == 6'h00)
    else $error("down counter not cleared by a low measurement");
  mid_hold_a: assert property (mid_meas_s
    |=> scale_r == $past(scale_r) && dn_cnt_r == $past(dn_cnt_r))
    else $error("mid-band measurement moved the regulator");
  rewrite_clamp_a: assert property (settings_rewrite_s
    |=> scale_r <= $past(cfg.current_scale) && scale_r >= $past(scale_floor))
    else $error("scale not clamped after a settings change");
  filter_reset_a: assert property (!cfg.load_filter_en && load_measurement_valid
    |=> filt_cnt_r == 2'h0 && filt_acc_r == '0)
    else $error("filter group not restarted while the filter is off");

endmodule // load_adaptive_current_spi_cfg

//--- spi_master_model.sv
// behavioural serial master that configures the regulator over the four-wire port
// assumes the device samples the pins with its own clock; sck idles high between frames
`timescale 1ns/1ps
module spi_master_model (
  output logic sck,
  output logic sdi,
  output logic csn,
  input wire logic sdo
);
  // link clock stands still high outside frames, except in idle_clocks, and chip select is off outside frames
  initial begin
    sck = 1'b1;
    sdi = 1'b0;
    csn = 1'b1;
  end

  // one frame, msb first; half sets the pace, so the same task serves fast and slow masters
  // sdo is taken just before each rising edge, half a period after the fall,
  // which leaves room for the device's synchroniser delay
  task automatic xfer(input logic [31:0] tx, input int nbits, input int half,
                      output logic [31:0] rx);
    rx = '0;
    csn = 1'b0;
    #(2 * half);
    for (int i = nbits - 1; i >= 0; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      #(half);
      rx = {rx[30:0], sdo};
      sck = 1'b1;
      #(half);
    end
    sdi = ~sdi; // a released line keeps no stale value
    csn = 1'b1;
    #(2 * half);
  endtask

  // serial clocks with chip select high, which the device must ignore
  task automatic idle_clocks(input int n);
    repeat (n) begin
      sck = 1'b0;
      sdi = ~sdi;
      #100;
      sck = 1'b1;
      #100;
    end
  endtask
endmodule // spi_master_model

//--- load_adaptive_current_spi_cfg_tb.sv
// self-checking bench for the load-adaptive current regulator and its serial port
// assumes the serial master model in its own file and the design package compiled first
`timescale 1ns/1ps
module load_adaptive_current_spi_cfg_tb
  import load_adaptive_current_pkg::*;
;
  logic core_clk;
  logic resetn;
  logic sck;
  logic sdi;
  logic csn;
  logic sdo;
  logic load_measurement_valid;
  regulator_cfg_t cfg;
  logic [9:0] load_measurement;
  logic [8:0] coil_a_in;
  logic [8:0] coil_b_in;
  logic [8:0] coil_a_out;
  logic [8:0] coil_b_out;
  logic [14:0] status_bits;
  logic [4:0] actual_current_scale;
  serial_cmd_t cmd;
  logic [19:0] got_word;
  logic [31:0] rx;
  int miscompares = 0;
  int check_count = 0;
  int valid_cnt = 0;
  int exp_scale;
  int dn_counts [4] = '{32, 8, 2, 1};

  load_adaptive_current_spi_cfg load_adaptive_current_spi_cfg_inst (
    .core_clk(core_clk), .resetn(resetn), .sck(sck), .sdi(sdi), .csn(csn), .sdo(sdo),
    .cfg(cfg), .load_measurement(load_measurement),
    .load_measurement_valid(load_measurement_valid), .coil_a_in(coil_a_in),
    .coil_b_in(coil_b_in), .coil_a_out(coil_a_out), .coil_b_out(coil_b_out),
    .status_bits(status_bits), .actual_current_scale(actual_current_scale), .cmd(cmd)
  );

  spi_master_model spi_master_model_inst (.sck(sck), .sdi(sdi), .csn(csn), .sdo(sdo));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // counts command pulses and keeps the last word, since valid stands one cycle only;
  // looked at on the falling edge, where the pulse is settled
  always @(negedge core_clk) begin
    if (cmd.valid === 1'b1) begin
      valid_cnt++;
      got_word = cmd.word;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic reset_dut();
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask

  // thresholds fixed: lower 2*32 = 64, upper (2+1+1)*32 = 128
  task automatic setcfg(input logic [4:0] cs, input logic [1:0] up, input logic [1:0] dn,
                        input logic q, input logic f);
    @(negedge core_clk);
    cfg = '{cs, up, dn, q, f, 4'h2, 4'h1};
    repeat (3) @(negedge core_clk);
  endtask

  task automatic pulse(input logic [9:0] v, input int n);
    repeat (n) begin
      @(negedge core_clk);
      load_measurement = v;
      load_measurement_valid = 1'b1;
      @(negedge core_clk);
      load_measurement_valid = 1'b0;
    end
    repeat (3) @(negedge core_clk);
  endtask

  task automatic coil_chk(input logic [4:0] s);
    @(negedge core_clk);
    coil_a_in = 9'h1FF;
    coil_b_in = 9'h0A5;
    repeat (2) @(negedge core_clk);
    check("coil_a_out", coil_a_out, (32'h1FF * (s + 32'h1)) >> 5);
    check("coil_b_out", coil_b_out, (32'h0A5 * (s + 32'h1)) >> 5);
  endtask

  // hang guard, well beyond the expected run of some tens of microseconds
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    load_measurement = 10'h000;
    load_measurement_valid = 1'b0;
    coil_a_in = 9'h000;
    coil_b_in = 9'h000;
    status_bits = 15'h5A3C;
    cfg = '{5'h1F, 2'h0, 2'h3, 1'b0, 1'b0, 4'h2, 4'h1};
    reset_dut();
    check("scale", actual_current_scale, 32'h1F);
    coil_chk(5'h1F);
    setcfg(5'h00, 2'h0, 2'h3, 1'b0, 1'b0);
    check("scale", actual_current_scale, 32'h00);
    coil_chk(5'h00);
    setcfg(5'h10, 2'h0, 2'h3, 1'b0, 1'b0);
    check("scale", actual_current_scale, 32'h08);
    coil_chk(5'h08);
    // serial port: plain frame, then a longer slow frame, then clocks without select
    setcfg(5'h1F, 2'h0, 2'h3, 1'b0, 1'b0);
    reset_dut();
    spi_master_model_inst.xfer(32'h000A5C3E, 20, 100, rx);
    repeat (4) @(negedge core_clk);
    check("cmd_count", valid_cnt, 32'h1);
    check("cmd_word", got_word, 32'h000A5C3E);
    check("resp_word", rx[19:0], {status_bits, 5'h1F});
    spi_master_model_inst.xfer(32'h00ABCDE5, 24, 300, rx);
    repeat (4) @(negedge core_clk);
    check("cmd_count", valid_cnt, 32'h2);
    check("cmd_word", got_word, 32'h000BCDE5);
    check("resp_word", rx[23:0], {status_bits, 5'h1F, 4'hA});
    spi_master_model_inst.idle_clocks(24);
    repeat (4) @(negedge core_clk);
    check("cmd_count", valid_cnt, 32'h2);
    // regulator: mid-band holds, then each decrement count
    exp_scale = 31;
    pulse(10'h07F, 1);
    check("scale", actual_current_scale, exp_scale);
    for (int c = 0; c < 4; c++) begin
      setcfg(5'h1F, 2'h0, c[1:0], 1'b0, 1'b0);
      pulse(10'h080, dn_counts[c] - 1);
      check("scale", actual_current_scale, exp_scale);
      pulse(10'h080, 1);
      exp_scale--;
      check("scale", actual_current_scale, exp_scale);
    end
    setcfg(5'h1F, 2'h0, 2'h3, 1'b0, 1'b0);
    pulse(10'h080, 20);
    check("scale", actual_current_scale, 32'h0F);
    setcfg(5'h1F, 2'h0, 2'h3, 1'b1, 1'b0);
    pulse(10'h080, 10);
    check("scale", actual_current_scale, 32'h07);
    exp_scale = 7;
    for (int c = 0; c < 4; c++) begin
      setcfg(5'h1F, c[1:0], 2'h3, 1'b1, 1'b0);
      pulse(10'h03F, 1);
      exp_scale += 1 << c;
      check("scale", actual_current_scale, exp_scale);
    end
    pulse(10'h03F, 2);
    check("scale", actual_current_scale, 32'h1F);
    pulse(10'h040, 1);
    check("scale", actual_current_scale, 32'h1F);
    // filter on: only the average of four counts, so single samples must not act
    setcfg(5'h1F, 2'h0, 2'h3, 1'b0, 1'b1);
    pulse(10'h0C8, 1);
    pulse(10'h064, 2);
    check("scale", actual_current_scale, 32'h1F);
    pulse(10'h070, 1);
    check("scale", actual_current_scale, 32'h1E);
    pulse(10'h000, 3);
    check("scale", actual_current_scale, 32'h1E);
    pulse(10'h0FF, 1);
    check("scale", actual_current_scale, 32'h1F);
    conclude();
  end
endmodule // load_adaptive_current_spi_cfg_tb
